// ==== design/alg_defs.svh ====
// Named constants for the audio link GPIO and PWM block.
// Assumes inclusion by its bare name from the design module.
`ifndef ALG_DEFS_SVH
`define ALG_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define ALG_ADDR_RX_LINK_STATUS 7'h06
`define ALG_ADDR_RX_INPUT_LEVELS 7'h07
`define ALG_ADDR_TX_OPERATING_MODES 7'h1A
`define ALG_ADDR_TX_AUX_INPUT_LEVELS 7'h20
`define ALG_ADDR_RX_OUTPUT_DRIVE 7'h41
`define ALG_ADDR_RX_PWM_ENABLE_RATE 7'h42
`define ALG_ADDR_RX_PWM_DUTY 7'h43

// ----------------------------------------------------------------------
// Reset values and field codes
// ----------------------------------------------------------------------
`define ALG_RESET_BYTE 8'h00
`define ALG_PWM_FUNC_OFF 2'h0
`define ALG_PWM_FUNC_ON 2'h3
`define ALG_SSEL_SPI 1'h0
`define ALG_SSEL_TWO_WIRE 1'h1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ALG_CLK_MHZ 50
`define ALG_PWM_REF_MHZ 16
`define ALG_PWM_STEPS 8'hFF

`endif

// ==== design/alg_pkg.sv ====
// Types shared by the audio link GPIO and PWM block.
// Assumes alg_defs.svh is on the include path.
package alg_pkg;

   // ----------------------------------------------------------------------
   // Register layouts
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic rf_tx_enable;
      logic audio_tx_power_down;
      logic wake_on_aux1;
      logic req_polarity;
      logic direct_mirror;
      logic spdif_enable;
      logic [1:0] mclk_control;
   } alg_tx_modes_t;

   typedef struct packed {
      logic exec_ok;
      logic gpio_mode;
      logic [5:0] reserved;
   } alg_link_status_t;

   typedef struct packed {
      logic strong_high_3;
      logic strong_low_2;
      logic strong_high_1;
      logic strong_low_0;
      logic [3:0] data;
   } alg_output_drive_t;

   typedef struct packed {
      logic [1:0] func;
      logic [5:0] rate;
   } alg_pwm_ctl_t;

   // ----------------------------------------------------------------------
   // Pin groups
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [3:0] level;
      logic [3:0] enable;
      logic [3:0] strong_high;
      logic [3:0] strong_low;
   } alg_gpio_out_t;

   typedef struct packed {
      logic rf_tx_enable;
      logic audio_tx_power_down;
      logic req_polarity;
      logic spdif_enable;
      logic [1:0] mclk_control;
   } alg_tx_ctl_t;

   // ----------------------------------------------------------------------
   // Whole module state
   // ----------------------------------------------------------------------
   typedef struct packed {
      alg_tx_modes_t tx_modes;
      logic [7:0] tx_aux_levels;
      logic aux1_prev;
      logic wake_flag;
      alg_link_status_t link_status;
      logic [3:0] rx_inputs;
      alg_output_drive_t out_drive;
      alg_pwm_ctl_t pwm_ctl;
      logic [7:0] pwm_duty;
      logic [6:0] ref_acc;
      logic [5:0] prescale;
      logic [7:0] step;
      alg_gpio_out_t gpio;
      logic [7:0] rdata;
      logic rvalid;
   } alg_state_t;

endpackage : alg_pkg

// ==== design/alg_gpio_pwm.sv ====
// Pin logic of a wireless audio streamer: transmitter aux inputs and mode
// register, receiver GPIO outputs with strong drive and PWM on output 3.
// Assumes a serial slave front end that delivers decoded byte accesses,
// and a configuration loader that reports its result with a pulse.
`timescale 1ns/1ps
`include "alg_defs.svh"

module alg_gpio_pwm
   import alg_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // Role and interface select straps
   input wire logic audio_receiver_role_in,
   input wire logic iface_select_in,
   // Decoded register access from the serial slave
   input wire logic [6:0] reg_addr_in,
   input wire logic reg_wr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_rd_in,
   output logic [7:0] reg_rdata_out,
   output logic reg_rvalid_out,
   // Configuration loader result
   input wire logic config_done_in,
   input wire logic config_exec_ok_in,
   input wire logic config_gpio_mode_in,
   // Transmitter pins and link side
   input wire logic [2:0] tx_aux_inputs_in,
   output logic [2:0] tx_mirror_levels_out,
   output logic tx_mirror_enable_out,
   output alg_tx_ctl_t tx_ctl_out,
   // Receiver link side
   input wire logic [2:0] link_mirror_levels_in,
   input wire logic link_mirror_enable_in,
   input wire logic master_cs_enable_in,
   input wire logic [2:0] master_cs_in,
   // Receiver pins
   input wire logic [3:0] rx_general_inputs_in,
   output alg_gpio_out_t rx_gpio_out,
   // Serial slave and interrupt
   output logic slave_enable_out,
   output logic slave_two_wire_out,
   input wire logic [7:0] int_sources_in,
   input wire logic wake_flag_clear_in,
   output logic wake_event_out,
   output logic irq_out
);

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   function automatic logic addr_is(input logic [6:0] a, input logic [6:0] ref_a);
      addr_is = (a == ref_a);
   endfunction : addr_is

   function automatic logic is_tx_reg(input logic [6:0] a);
      is_tx_reg = addr_is(a, `ALG_ADDR_TX_OPERATING_MODES) ||
                  addr_is(a, `ALG_ADDR_TX_AUX_INPUT_LEVELS);
   endfunction : is_tx_reg

   // Strong drive exists only on the pins that the drive bits name
   function automatic logic [3:0] strong_high_map(input alg_output_drive_t d);
      strong_high_map = {d.strong_high_3, 1'b0, d.strong_high_1, 1'b0};
   endfunction : strong_high_map

   function automatic logic [3:0] strong_low_map(input alg_output_drive_t d);
      strong_low_map = {1'b0, d.strong_low_2, 1'b0, d.strong_low_0};
   endfunction : strong_low_map

   // Chip selects beat the mirror, the mirror beats the data bits
   function automatic logic [2:0] low_level_sel(input logic cs_en, input logic [2:0] cs,
                                                input logic mir_en, input logic [2:0] mir,
                                                input logic [2:0] data);
      if (cs_en) begin
         low_level_sel = cs;
      end else if (mir_en) begin
         low_level_sel = mir;
      end else begin
         low_level_sel = data;
      end
   endfunction : low_level_sel

   // Step counter wraps after the last of the period's steps
   function automatic logic [7:0] pwm_step_next(input logic [7:0] s);
      if (s >= (`ALG_PWM_STEPS - 8'h01)) begin
         pwm_step_next = 8'h00;
      end else begin
         pwm_step_next = s + 8'h01;
      end
   endfunction : pwm_step_next

   // Duty 0 keeps the pin low, full duty keeps it high
   function automatic logic pwm_level(input logic [7:0] s, input logic [7:0] duty);
      pwm_level = (s < duty);
   endfunction : pwm_level

   // Read mux; unmapped offsets read as zero
   function automatic logic [7:0] read_value(input logic [6:0] a, input alg_state_t s);
      read_value = `ALG_RESET_BYTE;
      unique case (a)
         `ALG_ADDR_RX_LINK_STATUS: begin
            read_value = {s.link_status.exec_ok,
                          s.link_status.gpio_mode, 6'h00};
         end
         `ALG_ADDR_RX_INPUT_LEVELS: begin
            read_value = {4'h0, s.rx_inputs};
         end
         `ALG_ADDR_TX_OPERATING_MODES: begin
            read_value = s.tx_modes;
         end
         `ALG_ADDR_TX_AUX_INPUT_LEVELS: begin
            read_value = s.tx_aux_levels;
         end
         `ALG_ADDR_RX_OUTPUT_DRIVE: begin
            read_value = s.out_drive;
         end
         `ALG_ADDR_RX_PWM_ENABLE_RATE: begin
            read_value = s.pwm_ctl;
         end
         `ALG_ADDR_RX_PWM_DUTY: begin
            read_value = s.pwm_duty;
         end
         default: begin
            read_value = `ALG_RESET_BYTE;
         end
      endcase
   endfunction : read_value

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   alg_state_t st_ff;
   alg_state_t nxt_st;

   logic rx_role;
   logic gpio_active;
   logic two_wire;
   logic tx_access_ok;
   logic wake_event;
   logic ref_tick;
   logic pwm_on;
   logic [6:0] acc_sum;
   logic [2:0] low_levels;
   logic [3:0] strong_high_sel;
   logic [3:0] strong_low_sel;
   logic wr_tx_modes;
   logic wr_out_drive;
   logic wr_pwm_ctl;
   logic wr_pwm_duty;

   assign rx_role = audio_receiver_role_in;
   assign two_wire = (iface_select_in == `ALG_SSEL_TWO_WIRE);
   assign gpio_active = rx_role && st_ff.link_status.gpio_mode;
   assign tx_access_ok = !rx_role;
   assign pwm_on = (st_ff.pwm_ctl.func == `ALG_PWM_FUNC_ON);
   // Wake only from the transmitter mode register
   assign wake_event = !rx_role && st_ff.tx_modes.wake_on_aux1 &&
                       (tx_aux_inputs_in[1] != st_ff.aux1_prev);

   // Fractional accumulator gives an exact 16 MHz average from 50 MHz
   assign acc_sum = st_ff.ref_acc + 7'(`ALG_PWM_REF_MHZ);
   assign ref_tick = (acc_sum >= 7'(`ALG_CLK_MHZ));

   // ----------------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------------
   // Transmitter registers refuse writes in the receiver role
   assign wr_tx_modes = reg_wr_in && tx_access_ok &&
                        addr_is(reg_addr_in, `ALG_ADDR_TX_OPERATING_MODES);
   assign wr_out_drive = reg_wr_in && addr_is(reg_addr_in, `ALG_ADDR_RX_OUTPUT_DRIVE);
   assign wr_pwm_ctl = reg_wr_in && addr_is(reg_addr_in, `ALG_ADDR_RX_PWM_ENABLE_RATE);
   assign wr_pwm_duty = reg_wr_in && addr_is(reg_addr_in, `ALG_ADDR_RX_PWM_DUTY);

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.rvalid = 1'b0;
      low_levels = 3'h0;
      strong_high_sel = 4'h0;
      strong_low_sel = 4'h0;

      // Aux inputs, bit 2 shares the SPI data-in pin
      nxt_st.aux1_prev = tx_aux_inputs_in[1];
      nxt_st.tx_aux_levels = {5'h00, two_wire & tx_aux_inputs_in[2],
                              tx_aux_inputs_in[1:0]};

      // Wake flag: a set in the clearing cycle wins
      if (wake_flag_clear_in) begin
         nxt_st.wake_flag = 1'b0;
      end
      if (wake_event) begin
         nxt_st.wake_flag = 1'b1;
      end

      // Configuration result latched once loaded
      if (config_done_in) begin
         nxt_st.link_status.exec_ok = config_exec_ok_in;
         nxt_st.link_status.gpio_mode = config_gpio_mode_in;
      end

      // Inputs 3:2 share slave pins; frozen while the slave owns them
      nxt_st.rx_inputs[1:0] = rx_general_inputs_in[1:0];
      if (gpio_active) begin
         nxt_st.rx_inputs[3:2] = rx_general_inputs_in[3:2];
      end

      // Register writes
      if (wr_tx_modes) begin
         nxt_st.tx_modes = alg_tx_modes_t'(reg_wdata_in);
      end
      if (wr_out_drive) begin
         nxt_st.out_drive = alg_output_drive_t'(reg_wdata_in);
      end
      if (wr_pwm_ctl) begin
         nxt_st.pwm_ctl = alg_pwm_ctl_t'(reg_wdata_in);
      end
      if (wr_pwm_duty) begin
         nxt_st.pwm_duty = reg_wdata_in;
      end

      // Register reads, answered one cycle later; unmapped reads zero
      if (reg_rd_in) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = `ALG_RESET_BYTE;
         if (!is_tx_reg(reg_addr_in) || tx_access_ok) begin
            nxt_st.rdata = read_value(reg_addr_in, st_ff);
         end
      end

      // ----------------------------------------------------------------------
      // PWM timebase
      // ----------------------------------------------------------------------
      nxt_st.ref_acc = ref_tick ? (acc_sum - 7'(`ALG_CLK_MHZ)) : acc_sum;
      if (!pwm_on) begin
         // Restart the period so enabling starts cleanly
         nxt_st.prescale = 6'h00;
         nxt_st.step = 8'h00;
      end else if (ref_tick) begin
         if (st_ff.prescale >= st_ff.pwm_ctl.rate) begin
            nxt_st.prescale = 6'h00;
            nxt_st.step = pwm_step_next(st_ff.step);
         end else begin
            nxt_st.prescale = st_ff.prescale + 6'h01;
         end
      end

      // ----------------------------------------------------------------------
      // Receiver output pins
      // ----------------------------------------------------------------------
      low_levels = low_level_sel(master_cs_enable_in, master_cs_in, link_mirror_enable_in,
                                 link_mirror_levels_in, st_ff.out_drive.data[2:0]);
      strong_high_sel = strong_high_map(st_ff.out_drive);
      strong_low_sel = strong_low_map(st_ff.out_drive);

      if (gpio_active) begin
         nxt_st.gpio.level[2:0] = low_levels;
         if (pwm_on) begin
            nxt_st.gpio.level[3] = pwm_level(st_ff.step, st_ff.pwm_duty);
         end else begin
            nxt_st.gpio.level[3] = st_ff.out_drive.data[3];
         end
         nxt_st.gpio.enable = 4'hF;
         nxt_st.gpio.strong_high = strong_high_sel;
         nxt_st.gpio.strong_low = strong_low_sel;
      end else begin
         // Slave mode: pins belong to the serial port
         nxt_st.gpio = '0;
      end
   end

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_in) begin
      if (reset_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign reg_rdata_out = st_ff.rdata;
   assign reg_rvalid_out = st_ff.rvalid;
   assign rx_gpio_out = st_ff.gpio;

   // Mirror levels taken from the registered aux samples
   assign tx_mirror_levels_out = st_ff.tx_aux_levels[2:0];
   assign tx_mirror_enable_out = !rx_role && st_ff.tx_modes.direct_mirror;

   assign tx_ctl_out.rf_tx_enable = st_ff.tx_modes.rf_tx_enable;
   assign tx_ctl_out.audio_tx_power_down = st_ff.tx_modes.audio_tx_power_down;
   assign tx_ctl_out.req_polarity = st_ff.tx_modes.req_polarity;
   assign tx_ctl_out.spdif_enable = st_ff.tx_modes.spdif_enable;
   assign tx_ctl_out.mclk_control = st_ff.tx_modes.mclk_control;

   assign slave_enable_out = !gpio_active;
   assign slave_two_wire_out = two_wire;
   assign wake_event_out = wake_event;

   // In receiver GPIO mode the interrupt pin is held low
   always_comb begin
      if (gpio_active) begin
         irq_out = 1'b0;
      end else if (rx_role) begin
         irq_out = st_ff.wake_flag;
      end else begin
         irq_out = st_ff.wake_flag | (|int_sources_in);
      end
   end

endmodule : alg_gpio_pwm

// ==== testbench/alg_gpio_pwm_properties.sv ====
// Port assertions for the audio link GPIO and PWM block.
// Assumes a bind from the bench top onto alg_gpio_pwm.
`timescale 1ns/1ps
module alg_gpio_pwm_props
   import alg_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys_in,
   input wire logic reset_in,
   // Watched ports
   input wire logic audio_receiver_role_in,
   input wire logic iface_select_in,
   input wire logic [6:0] reg_addr_in,
   input wire logic reg_rd_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic reg_rvalid_out,
   input wire logic [2:0] tx_mirror_levels_out,
   input wire alg_gpio_out_t rx_gpio_out,
   input wire logic slave_enable_out,
   input wire logic slave_two_wire_out,
   input wire logic [7:0] int_sources_in,
   input wire logic wake_event_out,
   input wire logic irq_out
);
   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (reset_in);
   rd_answer_a: assert property (reg_rd_in |=> reg_rvalid_out)
      else $error("read not answered");
   port_select_a: assert property (slave_two_wire_out == iface_select_in)
      else $error("slave port choice wrong");
   drive_side_a: assert property ((rx_gpio_out.strong_high & 4'h5) == 4'h0
      && (rx_gpio_out.strong_low & 4'hA) == 4'h0) else $error("strong drive on wrong pin");
   slave_quiet_a: assert property (slave_enable_out && $past(slave_enable_out)
      |-> rx_gpio_out == 16'h0000) else $error("pins driven in slave mode");
   aux_spi_a: assert property (!iface_select_in && !$past(iface_select_in)
      |-> tx_mirror_levels_out[2] == 1'b0) else $error("aux 2 seen in spi mode");
   aux_reserved_a: assert property ($past(reg_rd_in) && $past(reg_addr_in) == 7'h20
      |-> reg_rdata_out[7:3] == 5'h00) else $error("aux reserved bits set");
   tx_irq_a: assert property (!audio_receiver_role_in && int_sources_in != 8'h00
      |-> irq_out) else $error("source did not raise irq");
   wake_irq_a: assert property (wake_event_out |-> ##[1:3] irq_out)
      else $error("wake did not raise irq");
endmodule : alg_gpio_pwm_props

// ==== testbench/alg_mcu_model.sv ====
// Microcontroller model on the decoded register port.
// Assumes the bench calls wr and rd; one byte per call.
`timescale 1ns/1ps
module alg_mcu_model (
   // Clock and answer
   input wire logic clk_sys_in,
   input wire logic [7:0] reg_rdata_in,
   input wire logic reg_rvalid_in,
   // Requests
   output logic [6:0] reg_addr_out,
   output logic reg_wr_out,
   output logic [7:0] reg_wdata_out,
   output logic reg_rd_out
);
   initial begin
      reg_addr_out = 7'h7F;
      reg_wr_out = 1'b0;
      reg_wdata_out = 8'h00;
      reg_rd_out = 1'b0;
   end
   // Idle bus shows inverted values, so stale data never looks valid
   // Byte port stands for a serial master kept within its rate limits
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr_out <= a;
      reg_wdata_out <= d;
      reg_wr_out <= 1'b1;
      @(posedge clk_sys_in);
      reg_wr_out <= 1'b0; // Idle cycle before next byte
      reg_addr_out <= ~a;
      reg_wdata_out <= ~d;
   endtask : wr
   task automatic rd(input logic [6:0] a, output logic [7:0] d);
      @(posedge clk_sys_in);
      reg_addr_out <= a;
      reg_rd_out <= 1'b1;
      @(posedge clk_sys_in);
      reg_rd_out <= 1'b0;
      reg_addr_out <= ~a;
      // Answer stands for the cycle after the read edge
      @(posedge clk_sys_in);
      d = reg_rvalid_in ? reg_rdata_in : 8'hxx;
   endtask : rd
endmodule : alg_mcu_model

// ==== testbench/tb.sv ====
// Self-checking bench for the audio link GPIO and PWM block.
// Assumes design, checker and microcontroller model are compiled first.
`timescale 1ns/1ps
module tb;
   import alg_pkg::*;
   logic clk_sys_in, reset_in, role, ssel, cfg_done, cfg_ok, cfg_gpio, lnk_en, cs_en, wclr;
   logic wr, rd, rvalid, mir_en, slv_en, slv_2w, wake, irq;
   logic [2:0] aux, lnk_lvl, cs, mir_lvl;
   logic [3:0] din;
   logic [6:0] addr;
   logic [7:0] ints, wdata, rdata;
   alg_tx_ctl_t tx_ctl;
   alg_gpio_out_t gpio;
   int miscompares = 0;
   int total_checks = 0;
   logic [6:0] ra [7] = '{7'h06, 7'h1A, 7'h20, 7'h41, 7'h42, 7'h43, 7'h55};
   alg_gpio_pwm u_dut (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
      .audio_receiver_role_in(role), .iface_select_in(ssel), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .reg_rvalid_out(rvalid), .config_done_in(cfg_done), .config_exec_ok_in(cfg_ok),
      .config_gpio_mode_in(cfg_gpio), .tx_aux_inputs_in(aux), .tx_mirror_levels_out(mir_lvl),
      .tx_mirror_enable_out(mir_en), .tx_ctl_out(tx_ctl), .link_mirror_levels_in(lnk_lvl),
      .link_mirror_enable_in(lnk_en), .master_cs_enable_in(cs_en), .master_cs_in(cs),
      .rx_general_inputs_in(din), .rx_gpio_out(gpio), .slave_enable_out(slv_en),
      .slave_two_wire_out(slv_2w), .int_sources_in(ints), .wake_flag_clear_in(wclr),
      .wake_event_out(wake), .irq_out(irq));
   alg_mcu_model u_mcu (.clk_sys_in(clk_sys_in), .reg_rdata_in(rdata),
      .reg_rvalid_in(rvalid), .reg_addr_out(addr), .reg_wr_out(wr),
      .reg_wdata_out(wdata), .reg_rd_out(rd));
   initial begin
      clk_sys_in = 1'b0;
      forever #10 clk_sys_in = ~clk_sys_in;
   end
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic rchk(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] d;
      u_mcu.rd(a, d);
      chk($sformatf("reg %h", a), {8'h00, d}, {8'h00, e});
   endtask : rchk
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys_in);
   endtask : tick
   // Tolerance covers the uneven 16 MHz tick spacing
   task automatic pwm_case(input logic [7:0] ctl, input logic [7:0] duty, input int hi_e,
      input int edg_e);
      integer hi;
      integer edg;
      logic prev;
      u_mcu.wr(7'h42, ctl);
      u_mcu.wr(7'h43, duty);
      tick(1000);
      hi = 0;
      edg = 0;
      prev = gpio.level[3];
      repeat (6375) begin
         @(posedge clk_sys_in);
         #1;
         hi += gpio.level[3];
         edg += gpio.level[3] && !prev;
         prev = gpio.level[3];
      end
      chk("pwm high", hi + 20 >= hi_e && hi <= hi_e + 20, 1'b1);
      chk("pwm edges", edg + 1 >= edg_e && edg <= edg_e + 1, 1'b1);
   endtask : pwm_case
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   initial begin
      tick(80000);
      miscompares++;
      give_verdict();
   end
   // ------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------
   initial begin
      {reset_in, ssel} = 2'h3;
      {role, cfg_done, cfg_ok, cfg_gpio, lnk_en, cs_en, wclr} = 7'h00;
      {aux, lnk_lvl, cs, din, ints} = 21'h0;
      tick(12);
      reset_in <= 1'b0;
      u_mcu.wr(7'h55, 8'hFF);
      foreach (ra[i]) rchk(ra[i], 8'h00);
      $display("test reset values done");
      u_mcu.wr(7'h1A, 8'hA5);
      rchk(7'h1A, 8'hA5);
      chk("tx ctl", tx_ctl, 16'h0025);
      @(posedge clk_sys_in);
      aux <= 3'b010;
      #1;
      chk("wake pulse", wake, 1'b1);
      tick(3);
      #1;
      chk("irq wake", irq, 1'b1);
      @(posedge clk_sys_in);
      wclr <= 1'b1;
      @(posedge clk_sys_in);
      wclr <= 1'b0;
      tick(2);
      chk("irq clear", irq, 1'b0);
      ints <= 8'h10;
      #2;
      chk("irq source", irq, 1'b1);
      @(posedge clk_sys_in);
      ints <= 8'h00;
      $display("test tx modes done");
      aux <= 3'b111;
      rchk(7'h20, 8'h07);
      @(posedge clk_sys_in);
      ssel <= 1'b0;
      rchk(7'h20, 8'h03);
      chk("slave 2w", slv_2w, 1'b0);
      u_mcu.wr(7'h1A, 8'h08);
      tick(2);
      chk("mirror en", mir_en, 1'b1);
      chk("mirror lvl", mir_lvl, 3'b011);
      u_mcu.wr(7'h1A, 8'h00);
      $display("test aux inputs done");
      @(posedge clk_sys_in);
      role <= 1'b1;
      ssel <= 1'b1;
      u_mcu.wr(7'h1A, 8'hFF);
      rchk(7'h1A, 8'h00);
      chk("tx ctl hold", tx_ctl, 16'h0000);
      u_mcu.wr(7'h41, 8'hFD);
      rchk(7'h41, 8'hFD);
      chk("gpio slave", gpio, 16'h0000);
      ints <= 8'hFF;
      din <= 4'hF;
      #1;
      chk("irq rx", irq, 1'b0);
      rchk(7'h07, 8'h03);
      @(posedge clk_sys_in);
      ints <= 8'h00;
      {cfg_done, cfg_ok, cfg_gpio} <= 3'h7;
      @(posedge clk_sys_in);
      cfg_done <= 1'b0;
      #1;
      chk("slave en", slv_en, 1'b0);
      rchk(7'h06, 8'hC0);
      chk("gpio out", gpio, 16'hDFA5);
      @(posedge clk_sys_in);
      din <= 4'hA;
      rchk(7'h07, 8'h0A);
      {lnk_en, lnk_lvl} <= 4'hA;
      tick(3);
      chk("lvl mirror", gpio.level, 4'hA);
      {cs_en, cs} <= 4'h9;
      tick(3);
      chk("lvl cs", gpio.level, 4'h9);
      $display("test receiver gpio done");
      pwm_case(8'hC0, 8'h80, 3200, 8);
      pwm_case(8'hC1, 8'h40, 1600, 4);
      pwm_case(8'hC0, 8'h00, 0, 0);
      pwm_case(8'hC0, 8'hFF, 6375, 0);
      pwm_case(8'h40, 8'h80, 6375, 0);
      pwm_case(8'h80, 8'h80, 6375, 0);
      pwm_case(8'h00, 8'h80, 6375, 0);
      $display("test pwm done");
      give_verdict();
   end
endmodule : tb
bind alg_gpio_pwm alg_gpio_pwm_props u_props (.clk_sys_in, .reset_in, .audio_receiver_role_in,
   .iface_select_in, .reg_addr_in, .reg_rd_in, .reg_rdata_out, .reg_rvalid_out,
   .tx_mirror_levels_out, .rx_gpio_out, .slave_enable_out, .slave_two_wire_out,
   .int_sources_in, .wake_event_out, .irq_out);
